// File: common/adc_path_defines.svh
// register offsets, field positions, reset values and timing counts of the output path
// Function
// - channel A codes: normal, zeros, ones, ramp
// - toggle code alternates AAA and 555 words
// - custom code outputs user word; 110/111 unused
// - channel B has own identical pattern selector
// - format 11 offset binary, else twos complement
// - channel B gain half-dB steps, zero default
// - offset loop bit five enables correction
// - user word from two registers, six each
// - interface 11 selects CMOS, else LVDS
// - buffer disable tri-states B, A, all+clock
// - digital gate bit three enables digital functions
// - two-bit codes shift output clock edges
// - standby bit, fast wakeup about 50 us
// - global power down, slow wakeup 100 us
// - all registers reset to zero, multi-field writes
`ifndef ADC_PATH_DEFINES_SVH
`define ADC_PATH_DEFINES_SVH

`define REG_SERIAL_CTRL           8'h00
`define REG_CHAN_A_PATTERN        8'h25
`define REG_OUTPUT_NUMBER_FORMAT  8'h29
`define REG_CHAN_B_GAIN_PATTERN   8'h2B
`define REG_OFFSET_LOOP_ENABLE    8'h3D
`define REG_USER_WORD_UPPER       8'h3F
`define REG_USER_WORD_LOWER       8'h40
`define REG_INTERFACE_BUFFER_CTRL 8'h41
`define REG_OUT_CLOCK_EDGE_GATE   8'h42
`define REG_POWER_DRIVE_CTRL      8'h45
`define REG_CHAN_B_FAST_MODE      8'h4A
`define REG_CHAN_A_FAST_MODE      8'h58

`define REG_RESET_VALUE           8'h00

`define READOUT_BIT               0
`define SOFT_RESET_BIT            1
`define PATTERN_LSB               0
`define FORMAT_LSB                3
`define GAIN_LSB                  4
`define OFFSET_ON_BIT             5
`define UPPER_LSB                 0
`define LOWER_LSB                 2
`define IFACE_LSB                 6
`define CMOS_STRENGTH_LSB         4
`define TRISTATE_LSB              0
`define FALL_SHIFT_LSB            6
`define RISE_SHIFT_LSB            4
`define DIGITAL_ON_BIT            3
`define STANDBY_BIT               7
`define LVDS_CLK_STRENGTH_BIT     6
`define LVDS_DATA_STRENGTH_BIT    5
`define POWER_DOWN_BIT            2
`define FAST_MODE_BIT             0

`define FORMAT_OFFSET_BINARY      2'h3
`define IFACE_CMOS                2'h3
`define TRISTATE_CHAN_B           2'h1
`define TRISTATE_CHAN_A           2'h2
`define TRISTATE_ALL              2'h3
`define GAIN_MAX_CODE             4'hC
`define TOGGLE_WORD_EVEN          12'hAAA
`define TOGGLE_WORD_ODD           12'h555
`define SERIAL_FRAME_LAST_BIT     4'hF
`define SERIAL_ADDR_LAST_BIT      4'h7
`define SERIAL_DATA_FIRST_BIT     4'h9

`define CLK_RATE_MHZ              25
`define STANDBY_WAKE_US           50
`define POWER_DOWN_WAKE_US        100
`define STANDBY_WAKE_CYCLES       (`STANDBY_WAKE_US * `CLK_RATE_MHZ)
`define POWER_DOWN_WAKE_CYCLES    (`POWER_DOWN_WAKE_US * `CLK_RATE_MHZ)

`endif

// File: common/adc_path_pkg.sv
// types shared by the serial port and the output path
package adc_path_pkg;

  typedef struct packed {
    logic       valid;
    logic [7:0] addr;
    logic [7:0] data;
  } reg_write_t;

  typedef enum logic [2:0] {
    PAT_NORMAL = 3'h0,
    PAT_ZEROS  = 3'h1,
    PAT_ONES   = 3'h2,
    PAT_TOGGLE = 3'h3,
    PAT_RAMP   = 3'h4,
    PAT_CUSTOM = 3'h5,
    PAT_UNUSED6 = 3'h6,
    PAT_UNUSED7 = 3'h7
  } pattern_t;

  typedef enum logic [1:0] {
    PWR_ON   = 2'h0,
    PWR_SLEEP = 2'h1,
    PWR_WAKE = 2'h3
  } power_state_t;

  typedef struct packed {
    logic        driveOff;
    logic [11:0] word;
  } lane_t;

endpackage : adc_path_pkg

// File: core/serial_reg_port.sv
// serial programming port: frames of address then data, with optional readout
`timescale 1ns/100ps
`default_nettype none
`include "adc_path_defines.svh"
module serial_reg_port
  import adc_path_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic       sclkPin,
  input  wire logic       senNPin,
  input  wire logic       sdataPin,
  input  wire logic       readoutOn,
  input  wire logic [7:0] rdData,
  output reg_write_t      regWrite,
  output logic [7:0]      rdAddr,
  output logic            sdout,
  output logic            sdoutOe_n
);

  logic [2:0]  pinMeta;
  logic [2:0]  pinSync;
  logic        sclkLast;
  logic [3:0]  bitCount;
  logic [14:0] shiftIn;
  logic [7:0]  shiftOut;
  logic        loadPending;
  logic        sclkRise;
  logic        sclkFall;
  logic        frameOn;

  // two-stage synchroniser for sclk, sen_n and sdata
  always_ff @(posedge clk) begin
    if (rst) begin
      pinMeta <= 3'h2;
      pinSync <= 3'h2;
    end else begin
      pinMeta <= {sdataPin, senNPin, sclkPin};
      pinSync <= pinMeta;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      sclkLast <= 1'b0;
    end else begin
      sclkLast <= pinSync[0];
    end
  end

  assign sclkRise = pinSync[0] & ~sclkLast;
  assign sclkFall = ~pinSync[0] & sclkLast;
  assign frameOn  = ~pinSync[1];

  always_ff @(posedge clk) begin
    if (rst || !frameOn) begin
      bitCount <= 4'h0;
      shiftIn  <= 15'h0000;
    end else if (sclkRise) begin
      bitCount <= bitCount + 4'h1;
      shiftIn  <= {shiftIn[13:0], pinSync[2]};
    end
  end

  // the whole byte of one frame is written at once, several fields together
  always_ff @(posedge clk) begin
    if (rst) begin
      regWrite <= '0;
    end else begin
      regWrite.valid <= frameOn && sclkRise && bitCount == `SERIAL_FRAME_LAST_BIT && !readoutOn;
      regWrite.addr  <= shiftIn[14:7];
      regWrite.data  <= {shiftIn[6:0], pinSync[2]};
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      rdAddr      <= 8'h00;
      loadPending <= 1'b0;
    end else begin
      loadPending <= frameOn && sclkRise && bitCount == `SERIAL_ADDR_LAST_BIT;
      if (frameOn && sclkRise && bitCount == `SERIAL_ADDR_LAST_BIT) begin
        rdAddr <= {shiftIn[6:0], pinSync[2]};
      end
    end
  end

  // readout data leaves msb first, moving on each falling sclk edge
  always_ff @(posedge clk) begin
    if (rst) begin
      shiftOut <= 8'h00;
    end else if (loadPending) begin
      shiftOut <= rdData;
    end else if (frameOn && sclkFall && bitCount >= `SERIAL_DATA_FIRST_BIT) begin
      shiftOut <= {shiftOut[6:0], 1'b0};
    end
  end

  assign sdout     = shiftOut[7];
  assign sdoutOe_n = ~readoutOn;

endmodule : serial_reg_port
`default_nettype wire

// File: core/adc_output_path_config.sv
// configuration registers and digital output path of the dual-channel converter
`timescale 1ns/100ps
`default_nettype none
`include "adc_path_defines.svh"
module adc_output_path_config
  import adc_path_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        sclkPin,
  input  wire logic        senNPin,
  input  wire logic        sdataPin,
  input  wire logic [11:0] chanARaw,
  input  wire logic [11:0] chanBRaw,
  output logic             sdout,
  output logic             sdoutOe_n,
  output logic [11:0]      chanAOut,
  output logic [11:0]      chanBOut,
  output logic             chanAOutOe_n,
  output logic             chanBOutOe_n,
  output logic             outClk,
  output logic             outClkOe_n,
  output logic             cmosMode,
  output logic [1:0]       fallShift,
  output logic [1:0]       riseShift,
  output logic [3:0]       chanBGainCode,
  output logic             offsetLoopActive,
  output logic             standbyActive,
  output logic             powerDownActive,
  output logic             chanBFastMode,
  output logic             chanAFastMode,
  output logic             converterReady
);

  localparam logic [11:0] STANDBY_WAKE = 12'(`STANDBY_WAKE_CYCLES);
  localparam logic [11:0] POWER_DOWN_WAKE = 12'(`POWER_DOWN_WAKE_CYCLES);

  reg_write_t   regWrite;
  logic [7:0]   rdAddr;
  logic [7:0]   rdData;
  logic         softReset;
  logic         clearRegs;

  logic         readoutOn;
  pattern_t     chanAPatternSelect;
  pattern_t     chanBPatternSelect;
  logic [1:0]   formatCode;
  logic [3:0]   chanBGain;
  logic         offsetLoopOn;
  logic [5:0]   userWordUpper;
  logic [5:0]   userWordLower;
  logic [1:0]   ifaceSelect;
  logic [1:0]   cmosClkStrength;
  logic [1:0]   bufferTristateSelect;
  logic [1:0]   outClockFallShift;
  logic [1:0]   outClockRiseShift;
  logic         digitalOn;
  logic         standbyBothChannels;
  logic         lvdsClkStrength;
  logic         lvdsDataStrength;
  logic         fullPowerDown;
  logic         chanBFastInput;
  logic         chanAFastInput;

  logic [11:0]  userWord;
  logic         togglePhase;
  logic [11:0]  rampWord;
  logic         sampleTick;
  power_state_t powerState;
  logic [11:0]  wakeCount;
  lane_t        next_laneA;
  lane_t        next_laneB;

  serial_reg_port port (
    .clk       (clk),
    .rst       (rst),
    .sclkPin   (sclkPin),
    .senNPin   (senNPin),
    .sdataPin  (sdataPin),
    .readoutOn (readoutOn),
    .rdData    (rdData),
    .regWrite  (regWrite),
    .rdAddr    (rdAddr),
    .sdout     (sdout),
    .sdoutOe_n (sdoutOe_n)
  );

  // substitutes a test word for converter data
  function automatic logic [11:0] patternWord(
    input pattern_t    sel,
    input logic [11:0] data,
    input logic        phase,
    input logic [11:0] ramp,
    input logic [11:0] custom
  );
    logic [11:0] word;
    word = data;
    unique case (sel)
      PAT_NORMAL:  word = data;
      PAT_ZEROS:   word = 12'h000;
      PAT_ONES:    word = 12'hFFF;
      PAT_TOGGLE:  word = phase ? `TOGGLE_WORD_ODD : `TOGGLE_WORD_EVEN;
      PAT_RAMP:    word = ramp;
      PAT_CUSTOM:  word = custom;
      PAT_UNUSED6: word = data;
      PAT_UNUSED7: word = data;
    endcase
    return word;
  endfunction : patternWord

  // converter data arrives in twos complement; offset binary flips the sign bit
  function automatic logic [11:0] numberFormat(
    input logic [11:0] data,
    input logic [1:0]  fmt
  );
    return (fmt == `FORMAT_OFFSET_BINARY) ? {~data[11], data[10:0]} : data;
  endfunction : numberFormat

  // one lane of output: test pattern when enabled, else formatted converter data
  function automatic lane_t laneWord(
    input pattern_t    sel,
    input logic [11:0] data,
    input logic        gate,
    input logic        driveOff
  );
    lane_t lane;
    lane.driveOff = driveOff;
    if (gate && sel != PAT_NORMAL) begin
      lane.word = patternWord(sel, data, togglePhase, rampWord, userWord);
    end else begin
      lane.word = numberFormat(data, formatCode);
    end
    return lane;
  endfunction : laneWord

  assign softReset = regWrite.valid && regWrite.addr == `REG_SERIAL_CTRL
                     && regWrite.data[`SOFT_RESET_BIT];
  assign clearRegs = rst || softReset;

  // register file; a soft reset clears every field and the bit itself is not kept
  always_ff @(posedge clk) begin
    if (clearRegs) begin
      readoutOn            <= 1'b0;
      chanAPatternSelect   <= PAT_NORMAL;
      chanBPatternSelect   <= PAT_NORMAL;
      formatCode           <= 2'h0;
      chanBGain            <= 4'h0;
      offsetLoopOn         <= 1'b0;
      userWordUpper        <= 6'h00;
      userWordLower        <= 6'h00;
      ifaceSelect          <= 2'h0;
      cmosClkStrength      <= 2'h0;
      bufferTristateSelect <= 2'h0;
      outClockFallShift    <= 2'h0;
      outClockRiseShift    <= 2'h0;
      digitalOn            <= 1'b0;
      standbyBothChannels  <= 1'b0;
      lvdsClkStrength      <= 1'b0;
      lvdsDataStrength     <= 1'b0;
      fullPowerDown        <= 1'b0;
      chanBFastInput       <= 1'b0;
      chanAFastInput       <= 1'b0;
    end else if (regWrite.valid) begin
      unique case (regWrite.addr)
        `REG_SERIAL_CTRL: begin
          readoutOn <= regWrite.data[`READOUT_BIT];
        end
        `REG_CHAN_A_PATTERN: begin
          chanAPatternSelect <= pattern_t'(regWrite.data[`PATTERN_LSB +: 3]);
        end
        `REG_OUTPUT_NUMBER_FORMAT: begin
          formatCode <= regWrite.data[`FORMAT_LSB +: 2];
        end
        `REG_CHAN_B_GAIN_PATTERN: begin
          chanBGain          <= regWrite.data[`GAIN_LSB +: 4];
          chanBPatternSelect <= pattern_t'(regWrite.data[`PATTERN_LSB +: 3]);
        end
        `REG_OFFSET_LOOP_ENABLE: begin
          offsetLoopOn <= regWrite.data[`OFFSET_ON_BIT];
        end
        `REG_USER_WORD_UPPER: begin
          userWordUpper <= regWrite.data[`UPPER_LSB +: 6];
        end
        `REG_USER_WORD_LOWER: begin
          userWordLower <= regWrite.data[`LOWER_LSB +: 6];
        end
        `REG_INTERFACE_BUFFER_CTRL: begin
          ifaceSelect          <= regWrite.data[`IFACE_LSB +: 2];
          cmosClkStrength      <= regWrite.data[`CMOS_STRENGTH_LSB +: 2];
          bufferTristateSelect <= regWrite.data[`TRISTATE_LSB +: 2];
        end
        `REG_OUT_CLOCK_EDGE_GATE: begin
          outClockFallShift <= regWrite.data[`FALL_SHIFT_LSB +: 2];
          outClockRiseShift <= regWrite.data[`RISE_SHIFT_LSB +: 2];
          digitalOn         <= regWrite.data[`DIGITAL_ON_BIT];
        end
        `REG_POWER_DRIVE_CTRL: begin
          standbyBothChannels <= regWrite.data[`STANDBY_BIT];
          lvdsClkStrength     <= regWrite.data[`LVDS_CLK_STRENGTH_BIT];
          lvdsDataStrength    <= regWrite.data[`LVDS_DATA_STRENGTH_BIT];
          fullPowerDown       <= regWrite.data[`POWER_DOWN_BIT];
        end
        `REG_CHAN_B_FAST_MODE: begin
          chanBFastInput <= regWrite.data[`FAST_MODE_BIT];
        end
        `REG_CHAN_A_FAST_MODE: begin
          chanAFastInput <= regWrite.data[`FAST_MODE_BIT];
        end
        default: begin
        end
      endcase
    end
  end

  // readback of the held fields; reserved bits read as zero
  always_comb begin
    rdData = 8'h00;
    unique case (rdAddr)
      `REG_SERIAL_CTRL:           rdData[`READOUT_BIT] = readoutOn;
      `REG_CHAN_A_PATTERN:        rdData[`PATTERN_LSB +: 3] = chanAPatternSelect;
      `REG_OUTPUT_NUMBER_FORMAT:  rdData[`FORMAT_LSB +: 2] = formatCode;
      `REG_CHAN_B_GAIN_PATTERN:   rdData = {chanBGain, 1'b0, chanBPatternSelect};
      `REG_OFFSET_LOOP_ENABLE:    rdData[`OFFSET_ON_BIT] = offsetLoopOn;
      `REG_USER_WORD_UPPER:       rdData[`UPPER_LSB +: 6] = userWordUpper;
      `REG_USER_WORD_LOWER:       rdData[`LOWER_LSB +: 6] = userWordLower;
      `REG_INTERFACE_BUFFER_CTRL: rdData = {ifaceSelect, cmosClkStrength, 2'h0,
                                            bufferTristateSelect};
      `REG_OUT_CLOCK_EDGE_GATE:   rdData = {outClockFallShift, outClockRiseShift,
                                            digitalOn, 3'h0};
      `REG_POWER_DRIVE_CTRL:      rdData = {standbyBothChannels, lvdsClkStrength,
                                            lvdsDataStrength, 2'h0, fullPowerDown, 2'h0};
      `REG_CHAN_B_FAST_MODE:      rdData[`FAST_MODE_BIT] = chanBFastInput;
      `REG_CHAN_A_FAST_MODE:      rdData[`FAST_MODE_BIT] = chanAFastInput;
      default:                    rdData = 8'h00;
    endcase
  end

  assign userWord = {userWordUpper, userWordLower};

  // output clock runs at half the core clock; words launch as it falls
  always_ff @(posedge clk) begin
    if (rst) begin
      outClk <= 1'b0;
    end else begin
      outClk <= ~outClk;
    end
  end

  assign sampleTick = outClk;

  always_ff @(posedge clk) begin
    if (rst) begin
      togglePhase <= 1'b0;
    end else if (sampleTick) begin
      togglePhase <= ~togglePhase;
    end
  end

  // ramp steps once per sample and rolls over from FFF to 000
  always_ff @(posedge clk) begin
    if (rst) begin
      rampWord <= 12'h000;
    end else if (sampleTick) begin
      rampWord <= rampWord + 12'h001;
    end
  end

  always_comb begin
    next_laneA = laneWord(chanAPatternSelect, chanARaw, digitalOn,
                          fullPowerDown || bufferTristateSelect == `TRISTATE_CHAN_A
                          || bufferTristateSelect == `TRISTATE_ALL);
    next_laneB = laneWord(chanBPatternSelect, chanBRaw, digitalOn,
                          fullPowerDown || bufferTristateSelect == `TRISTATE_CHAN_B
                          || bufferTristateSelect == `TRISTATE_ALL);
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      chanAOut <= 12'h000;
      chanBOut <= 12'h000;
    end else if (sampleTick) begin
      chanAOut <= next_laneA.word;
      chanBOut <= next_laneB.word;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      chanAOutOe_n <= 1'b0;
      chanBOutOe_n <= 1'b0;
      outClkOe_n   <= 1'b0;
    end else begin
      chanAOutOe_n <= next_laneA.driveOff;
      chanBOutOe_n <= next_laneB.driveOff;
      outClkOe_n   <= fullPowerDown || bufferTristateSelect == `TRISTATE_ALL;
    end
  end

  // controls handed to the analog and interface sections
  always_ff @(posedge clk) begin
    if (rst) begin
      cmosMode         <= 1'b0;
      fallShift        <= 2'h0;
      riseShift        <= 2'h0;
      chanBGainCode    <= 4'h0;
      offsetLoopActive <= 1'b0;
      chanBFastMode    <= 1'b0;
      chanAFastMode    <= 1'b0;
    end else begin
      cmosMode         <= ifaceSelect == `IFACE_CMOS;
      fallShift        <= outClockFallShift;
      riseShift        <= outClockRiseShift;
      chanBGainCode    <= !digitalOn ? 4'h0 :
                          (chanBGain > `GAIN_MAX_CODE) ? `GAIN_MAX_CODE : chanBGain;
      offsetLoopActive <= digitalOn && offsetLoopOn;
      chanBFastMode    <= chanBFastInput;
      chanAFastMode    <= chanAFastInput;
    end
  end

  // sleep while either bit is set, then count the wake time of the deeper mode
  always_ff @(posedge clk) begin
    if (rst) begin
      powerState <= PWR_ON;
      wakeCount  <= 12'h000;
    end else begin
      unique case (powerState)
        PWR_ON: begin
          if (fullPowerDown || standbyBothChannels) begin
            powerState <= PWR_SLEEP;
          end
        end
        PWR_SLEEP: begin
          if (fullPowerDown) begin
            wakeCount <= POWER_DOWN_WAKE - 12'h001;
          end else if (standbyBothChannels) begin
            wakeCount <= (wakeCount > STANDBY_WAKE) ? wakeCount : STANDBY_WAKE - 12'h001;
          end else begin
            powerState <= PWR_WAKE;
          end
        end
        PWR_WAKE: begin
          if (fullPowerDown || standbyBothChannels) begin
            powerState <= PWR_SLEEP;
          end else if (wakeCount == 12'h000) begin
            powerState <= PWR_ON;
          end else begin
            wakeCount <= wakeCount - 12'h001;
          end
        end
        default: begin
          powerState <= PWR_ON;
        end
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      standbyActive   <= 1'b0;
      powerDownActive <= 1'b0;
      converterReady  <= 1'b0;
    end else begin
      standbyActive   <= standbyBothChannels;
      powerDownActive <= fullPowerDown;
      converterReady  <= powerState == PWR_ON;
    end
  end

endmodule : adc_output_path_config
`default_nettype wire

// File: tb/adc_path_checker_sva.sv
// port-level assertions for the converter output path
`timescale 1ns/100ps
`default_nettype none
module adc_path_checker (
  input wire logic        clk,
  input wire logic        rst,
  input wire logic        outClk,
  input wire logic        outClkOe_n,
  input wire logic        chanAOutOe_n,
  input wire logic        chanBOutOe_n,
  input wire logic [11:0] chanAOut,
  input wire logic [11:0] chanBOut,
  input wire logic [3:0]  chanBGainCode,
  input wire logic        cmosMode,
  input wire logic        standbyActive,
  input wire logic        powerDownActive,
  input wire logic        converterReady
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  reset_zero_a: assert property (
    $past(rst) |-> chanBGainCode == 4'h0 && !cmosMode && !powerDownActive && !standbyActive)
    else $error("outputs not cleared by reset");
  gain_clamp_a: assert property (
    chanBGainCode <= 4'hC) else $error("gain code above 6 dB");
  bufs_off_a: assert property (
    outClkOe_n |-> chanAOutOe_n && chanBOutOe_n) else $error("clock off with data driven");
  clk_toggle_a: assert property (
    !$past(rst) && !powerDownActive |-> outClk != $past(outClk))
    else $error("output clock stalled");
  word_steady_a: assert property (
    $rose(outClk) |-> $stable(chanAOut) && $stable(chanBOut))
    else $error("word changed at capture edge");
  standby_drop_a: assert property (
    $rose(standbyActive) |-> ##[0:2] !converterReady) else $error("standby kept ready");
  pdn_drop_a: assert property (
    $rose(powerDownActive) |-> ##[0:2] !converterReady) else $error("power down kept ready");
  pdn_tristate_a: assert property (
    powerDownActive [*2] |-> outClkOe_n && chanAOutOe_n)
    else $error("buffers driven in power down");
  wake_delay_a: assert property (
    $fell(standbyActive) && !powerDownActive |-> !converterReady [*8])
    else $error("standby wake too fast");
endmodule : adc_path_checker
bind adc_output_path_config adc_path_checker chk_u (.clk, .rst, .outClk, .outClkOe_n,
  .chanAOutOe_n, .chanBOutOe_n, .chanAOut, .chanBOut, .chanBGainCode, .cmosMode,
  .standbyActive, .powerDownActive, .converterReady);
`default_nettype wire

// File: tb/sample_receiver.sv
// receiver model capturing sample words on the output clock rise
`timescale 1ns/100ps
`default_nettype none
module sample_receiver (
  input  wire logic        clk,
  input  wire logic        outClk,
  input  wire logic        outClkOe_n,
  input  wire logic        chanAOutOe_n,
  input  wire logic        chanBOutOe_n,
  input  wire logic [11:0] chanAOut,
  input  wire logic [11:0] chanBOut,
  output logic [11:0]      capA,
  output logic [11:0]      capB,
  output logic             got
);
  logic prevClk;
  // released lines show garbage, not the last word
  always_ff @(posedge clk) begin
    prevClk <= outClk;
    got     <= 1'b0;
    if (outClk && !prevClk && !outClkOe_n) begin
      capA <= chanAOutOe_n ? ~capA : chanAOut;
      capB <= chanBOutOe_n ? ~capB : chanBOut;
      got  <= 1'b1;
    end
  end
endmodule : sample_receiver
`default_nettype wire

// File: tb/adc_output_path_config_test.sv
// testbench of the converter output path
`timescale 1ns/100ps
`default_nettype none
module adc_output_path_config_test;
  logic        clk, rst, sclkPin, senNPin, sdataPin, rxGot, sdout, sdoutOe_n;
  logic [7:0]  rb;
  logic [11:0] chanARaw, chanBRaw, chanAOut, chanBOut, pa, pb, qa, qb, rxA, rxB;
  logic        chanAOutOe_n, chanBOutOe_n, outClk, outClkOe_n, cmosMode;
  logic [1:0]  fallShift, riseShift;
  logic [3:0]  chanBGainCode;
  logic        offsetLoopActive, standbyActive, powerDownActive;
  logic        chanBFastMode, chanAFastMode, converterReady;
  int          fails, comparisons, wk;
  adc_output_path_config dut_u (.clk, .rst, .sclkPin, .senNPin, .sdataPin, .chanARaw,
    .chanBRaw, .sdout, .sdoutOe_n, .chanAOut, .chanBOut, .chanAOutOe_n, .chanBOutOe_n,
    .outClk, .outClkOe_n, .cmosMode, .fallShift, .riseShift, .chanBGainCode,
    .offsetLoopActive, .standbyActive, .powerDownActive, .chanBFastMode, .chanAFastMode,
    .converterReady);
  sample_receiver rx_u (.clk, .outClk, .outClkOe_n, .chanAOutOe_n, .chanBOutOe_n,
    .chanAOut, .chanBOut, .capA(rxA), .capB(rxB), .got(rxGot));
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  always @(posedge clk) begin
    if (standbyActive || powerDownActive) wk <= 0;
    else if (!converterReady) wk <= wk + 1;
  end
  task tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : tick
  task chk(input string n, input logic [11:0] e, input logic [11:0] s);
    comparisons++;
    if (s !== e) begin
      fails++;
      $display("Error %s expected %h seen %h", n, e, s);
    end
  endtask : chk
  task wr(input logic [7:0] a, input logic [7:0] d);
    logic [15:0] f;
    f = {a, d};
    senNPin = 1'b0;
    for (int i = 15; i >= 0; i--) begin
      sdataPin = f[i];
      tick(4);
      if (i < 8) rb = {rb[6:0], sdout};
      sclkPin = 1'b1;
      tick(4);
      sclkPin = 1'b0;
    end
    tick(4);
    senNPin = 1'b1;
    sdataPin = ~f[0];
    tick(12);
  endtask : wr
  task cap(output logic [11:0] a, output logic [11:0] b);
    tick(1);
    for (int k = 0; k < 8 && rxGot !== 1'b1; k++) tick(1);
    a = rxA;
    b = rxB;
  endtask : cap
  function automatic logic [11:0] pat(input logic [2:0] c, input logic [11:0] raw, p);
    case (c)
      3'h1: return 12'h000;
      3'h2: return 12'hFFF;
      3'h3: return (p === 12'hAAA) ? 12'h555 : 12'hAAA;
      3'h4: return p + 12'h001;
      3'h5: return 12'hB5A;
      default: return raw;
    endcase
  endfunction : pat
  task results;
    $display("comparisons %0d fails %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : results
  initial begin
    #2000000;
    fails++;
    results();
  end
  initial begin
    rst = 1'b1;
    {sclkPin, sdataPin, senNPin} = 3'b001;
    chanARaw = 12'h123;
    chanBRaw = 12'h7C5;
    tick(2);
    rst = 1'b0;
    tick(3);
    wr(8'h3F, 8'h2D);
    wr(8'h40, 8'h68);
    wr(8'h42, 8'h08);
    for (int c = 0; c < 8; c++) begin
      wr(8'h25, c[7:0]);
      wr(8'h2B, c[7:0]);
      cap(pa, pb);
      cap(pa, pb);
      cap(qa, qb);
      chk("chanA word", pat(c[2:0], chanARaw, pa), qa);
      chk("chanB word", pat(c[2:0], chanBRaw, pb), qb);
    end
    wr(8'h25, 8'h04);
    cap(pa, pb);
    for (int n = 0; n < 4097; n++) begin
      cap(qa, qb);
      chk("ramp", pa + 12'h001, qa);
      pa = qa;
    end
    wr(8'h25, 8'h02);
    wr(8'h2B, 8'hA0);
    wr(8'h3D, 8'h20);
    wr(8'h42, 8'h00);
    cap(qa, qb);
    cap(qa, qb);
    chk("gate off word", chanARaw, qa);
    chk("gate off gain", 4'h0, chanBGainCode);
    chk("gate off offset", 1'b0, offsetLoopActive);
    wr(8'h42, 8'h08);
    cap(qa, qb);
    cap(qa, qb);
    chk("gate on word", 12'hFFF, qa);
    chk("offset on", 1'b1, offsetLoopActive);
    wr(8'h3D, 8'h00);
    chk("offset off", 1'b0, offsetLoopActive);
    for (int g = 0; g < 16; g++) begin
      wr(8'h2B, {g[3:0], 4'h0});
      chk("gain", (g > 12) ? 4'hC : g[3:0], chanBGainCode);
    end
    wr(8'h25, 8'h00);
    for (int f = 0; f < 4; f++) begin
      wr(8'h29, {3'h0, f[1:0], 3'h0});
      cap(qa, qb);
      cap(qa, qb);
      chk("format", (f == 3) ? chanARaw ^ 12'h800 : chanARaw, qa);
    end
    for (int i = 0; i < 4; i++) begin
      wr(8'h41, {i[1:0], 4'h0, i[1:0]});
      chk("cmos", i == 3, cmosMode);
      chk("chanA off", i[1], chanAOutOe_n);
      chk("chanB off", i[0], chanBOutOe_n);
      chk("clock off", i == 3, outClkOe_n);
    end
    wr(8'h41, 8'h00);
    wr(8'h42, 8'h78);
    chk("fall shift", 2'h1, fallShift);
    chk("rise shift", 2'h3, riseShift);
    wr(8'h4A, 8'h01);
    wr(8'h58, 8'h01);
    chk("fast B", 1'b1, chanBFastMode);
    chk("fast A", 1'b1, chanAFastMode);
    wr(8'h00, 8'h02);
    chk("soft reset", 1'b0, chanBFastMode);
    for (int p = 0; p < 2; p++) begin
      wr(8'h45, p ? 8'h04 : 8'h80);
      chk("asleep", 1'b1, p ? powerDownActive : standbyActive);
      chk("ready low", 1'b0, converterReady);
      wr(8'h45, 8'h00);
      for (int k = 0; k < 3000 && converterReady !== 1'b1; k++) tick(1);
      chk("wake", 1'b1, wk >= (p ? 2498 : 1248) && wk <= (p ? 2510 : 1260));
    end
    wr(8'h2B, 8'h52);
    wr(8'h00, 8'h01);
    chk("readout on", 1'b0, sdoutOe_n);
    wr(8'h2B, 8'h00);
    chk("readback", 8'h52, rb);
    wr(8'h2B, 8'h00);
    chk("refused write", 8'h52, rb);
    rst = 1'b1;
    tick(2);
    rst = 1'b0;
    tick(3);
    chk("readout off", 1'b1, sdoutOe_n);
    chk("reset gain", 4'h0, chanBGainCode);
    chk("reset fast", 1'b0, chanBFastMode);
    cap(qa, qb);
    cap(qa, qb);
    chk("reset word", chanBRaw, qb);
    results();
  end
endmodule : adc_output_path_config_test
`default_nettype wire
